/* rtl/switch_forward_mac_control_defines.svh */
`ifndef SWITCH_FORWARD_MAC_CONTROL_DEFINES_SVH
`define SWITCH_FORWARD_MAC_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte addresses on the management port
// ----------------------------------------------------------------------------
`define UNKNOWN_VLAN_FORWARD_CONTROL_ADDR 16'h0328
`define SWITCH_MAC_CONTROL_ZERO_ADDR 16'h0330

// ----------------------------------------------------------------------------
// unknown vlan forward control fields
// ----------------------------------------------------------------------------
`define UVF_ENABLE_BIT 31
`define UVF_MASK_MSB 2
`define UVF_MASK_LSB 0
`define UVF_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// switch mac control zero fields
// ----------------------------------------------------------------------------
`define MC0_ALT_BACKOFF_BIT 7
`define MC0_LENGTH_CHECK_BIT 3
`define MC0_FC_DROP_EITHER_BIT 1
`define MC0_AGGR_BACKOFF_BIT 0
`define MC0_RESET 8'h0e

// ----------------------------------------------------------------------------
// frame field constants
// ----------------------------------------------------------------------------
`define LENGTH_FIELD_LIMIT 16'h05dc
`define FLOW_CONTROL_ETHERTYPE 16'h8808
`define FLOW_CONTROL_DEST_ADDR 48'h0180_c200_0001
`define PORT_COUNT 3

`endif

/* rtl/switch_forward_mac_control_pkg.sv */
package switch_forward_mac_control_pkg;

	// ------------------------------------------------------------------------
	// unknown-frame category applied to a frame
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CAT_NONE = 2'h0,
		CAT_UNKNOWN_VLAN = 2'h1,
		CAT_UNKNOWN_UNICAST = 2'h2,
		CAT_UNKNOWN_MULTICAST = 2'h3
	} unknown_category_t;

endpackage : switch_forward_mac_control_pkg

/* rtl/unknown_forward_select.sv */
`timescale 1ns/100ps
`include "switch_forward_mac_control_defines.svh"

module unknown_forward_select (
	// frame classification
	input wire logic vid_unknown_i,
	input wire logic uc_unknown_i,
	input wire logic mc_unknown_i,
	// per-category settings
	input wire logic vlan_enable_i,
	input wire logic [`PORT_COUNT-1:0] vlan_mask_i,
	input wire logic uc_enable_i,
	input wire logic [`PORT_COUNT-1:0] uc_mask_i,
	input wire logic mc_enable_i,
	input wire logic [`PORT_COUNT-1:0] mc_mask_i,
	// decision
	output switch_forward_mac_control_pkg::unknown_category_t category_o,
	output logic flood_o,
	output logic [`PORT_COUNT-1:0] port_mask_o
);

	// vlan wins, then unicast, then multicast; a disabled category still
	// claims the frame so a lower one cannot forward it
	always_comb begin
		category_o = switch_forward_mac_control_pkg::CAT_NONE;
		flood_o = 1'b0;
		port_mask_o = '0;
		if (vid_unknown_i) begin
			category_o = switch_forward_mac_control_pkg::CAT_UNKNOWN_VLAN;
			flood_o = vlan_enable_i;
			port_mask_o = vlan_enable_i ? vlan_mask_i : '0;
		end else if (uc_unknown_i) begin
			category_o = switch_forward_mac_control_pkg::CAT_UNKNOWN_UNICAST;
			flood_o = uc_enable_i;
			port_mask_o = uc_enable_i ? uc_mask_i : '0;
		end else if (mc_unknown_i) begin
			category_o = switch_forward_mac_control_pkg::CAT_UNKNOWN_MULTICAST;
			flood_o = mc_enable_i;
			port_mask_o = mc_enable_i ? mc_mask_i : '0;
		end
	end

endmodule : unknown_forward_select

/* rtl/frame_drop_check.sv */
`timescale 1ns/100ps
`include "switch_forward_mac_control_defines.svh"

module frame_drop_check (
	// settings
	input wire logic length_check_en_i,
	input wire logic fc_drop_either_i,
	// frame fields
	input wire logic [15:0] len_type_i,
	input wire logic [15:0] data_length_i,
	input wire logic [47:0] dest_addr_i,
	// verdicts
	output logic length_drop_o,
	output logic fc_drop_o
);

	logic is_fc_type;
	logic is_fc_da;

	// length field only meaningful below the limit
	assign length_drop_o = length_check_en_i && (len_type_i < `LENGTH_FIELD_LIMIT)
		&& (data_length_i != len_type_i);

	// flow control frame recognition
	assign is_fc_type = (len_type_i == `FLOW_CONTROL_ETHERTYPE);
	assign is_fc_da = (dest_addr_i == `FLOW_CONTROL_DEST_ADDR);
	assign fc_drop_o = fc_drop_either_i ? (is_fc_type || is_fc_da)
		: (is_fc_type && is_fc_da);

endmodule : frame_drop_check

/* rtl/switch_forward_mac_control.sv */
`timescale 1ns/100ps
`include "switch_forward_mac_control_defines.svh"

// How it works
// - with the unknown vlan enable set, frames of unknown vid go to the masked ports, else not.
// - mask bit 0, 1 and 2 select ports 1, 2 and 3; a set bit includes the port.
// - after reset the unknown vlan enable and all three mask bits are zero.
// - unknown vlan handling takes precedence over unknown unicast, which beats unknown multicast.
// - the alternate back-off bit selects alternate back-off, only on half-duplex ports.
// - with length check set, a frame whose field is below 1500 and differs in length is dropped.
// - with drop mode set, a frame with type 0x8808 or the pause address is dropped.
// - with drop mode clear, a frame is dropped only with both the type and the pause address.
// - the aggressive back-off bit turns the aggressive half-duplex back-pressure algorithm on.
// - after reset length check and drop mode are one, both back-off bits are zero.

module switch_forward_mac_control (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// management port register access, one byte per access
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// frame descriptor from the lookup stage
	input wire logic frame_valid_i,
	input wire logic frame_vid_unknown_i,
	input wire logic frame_uc_unknown_i,
	input wire logic frame_mc_unknown_i,
	input wire logic [15:0] frame_len_type_i,
	input wire logic [15:0] frame_data_length_i,
	input wire logic [47:0] frame_dest_addr_i,
	// settings of the neighbouring unknown-frame registers
	input wire logic uc_forward_en_i,
	input wire logic [`PORT_COUNT-1:0] uc_port_mask_i,
	input wire logic mc_forward_en_i,
	input wire logic [`PORT_COUNT-1:0] mc_port_mask_i,
	// frame decision
	output logic decision_valid_o,
	output logic decision_drop_o,
	output logic decision_length_drop_o,
	output logic decision_fc_drop_o,
	output logic decision_flood_o,
	output logic [`PORT_COUNT-1:0] decision_port_mask_o,
	output switch_forward_mac_control_pkg::unknown_category_t decision_category_o,
	// per-port mac controls
	input wire logic [`PORT_COUNT-1:0] port_half_duplex_i,
	output logic [`PORT_COUNT-1:0] alt_backoff_o,
	output logic [`PORT_COUNT-1:0] aggr_backoff_o,
	// global mac settings
	output logic length_check_en_o,
	output logic fc_drop_either_o
);

	// ------------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------------
	logic uvf_enable_reg;
	logic [`PORT_COUNT-1:0] uvf_mask_reg;
	logic [7:0] mac_control_zero_reg;

	// decode helpers shared by write and read paths
	function automatic logic hits_uvf(input logic [15:0] addr, input logic [1:0] lane);
		hits_uvf = (addr == (`UNKNOWN_VLAN_FORWARD_CONTROL_ADDR + {14'h0000, lane}));
	endfunction : hits_uvf

	function automatic logic hits_mc0(input logic [15:0] addr);
		hits_mc0 = (addr == `SWITCH_MAC_CONTROL_ZERO_ADDR);
	endfunction : hits_mc0

	// ------------------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------------------
	// big-endian byte order: the lowest address carries bits 31:24
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			uvf_enable_reg <= 1'(`UVF_RESET >> `UVF_ENABLE_BIT);
			uvf_mask_reg <= `PORT_COUNT'(`UVF_RESET);
		end else if (reg_write_i) begin
			if (hits_uvf(reg_addr_i, 2'h0)) begin
				uvf_enable_reg <= reg_wdata_i[7];
			end else if (hits_uvf(reg_addr_i, 2'h3)) begin
				uvf_mask_reg <= reg_wdata_i[`UVF_MASK_MSB:`UVF_MASK_LSB];
			end
		end
	end

	// reserved bits of this byte are writable and keep their value
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			mac_control_zero_reg <= `MC0_RESET;
		end else if (reg_write_i && hits_mc0(reg_addr_i)) begin
			mac_control_zero_reg <= reg_wdata_i;
		end
	end

	// ------------------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------------------
	logic [7:0] read_value;

	// unmapped bytes and reserved fields of the vlan register read as zero
	always_comb begin
		read_value = 8'h00;
		if (hits_uvf(reg_addr_i, 2'h0)) begin
			read_value = {uvf_enable_reg, 7'h00};
		end else if (hits_uvf(reg_addr_i, 2'h3)) begin
			read_value = {5'h00, uvf_mask_reg};
		end else if (hits_mc0(reg_addr_i)) begin
			read_value = mac_control_zero_reg;
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_read_i;
			if (reg_read_i) begin
				reg_rdata_o <= read_value;
			end
		end
	end

	// ------------------------------------------------------------------------
	// frame decision
	// ------------------------------------------------------------------------
	switch_forward_mac_control_pkg::unknown_category_t category;
	logic flood;
	logic [`PORT_COUNT-1:0] port_mask;
	logic length_drop;
	logic fc_drop;

	unknown_forward_select u_select (
		.vid_unknown_i(frame_vid_unknown_i),
		.uc_unknown_i(frame_uc_unknown_i),
		.mc_unknown_i(frame_mc_unknown_i),
		.vlan_enable_i(uvf_enable_reg),
		.vlan_mask_i(uvf_mask_reg),
		.uc_enable_i(uc_forward_en_i),
		.uc_mask_i(uc_port_mask_i),
		.mc_enable_i(mc_forward_en_i),
		.mc_mask_i(mc_port_mask_i),
		.category_o(category),
		.flood_o(flood),
		.port_mask_o(port_mask)
	);

	frame_drop_check u_drop (
		.length_check_en_i(mac_control_zero_reg[`MC0_LENGTH_CHECK_BIT]),
		.fc_drop_either_i(mac_control_zero_reg[`MC0_FC_DROP_EITHER_BIT]),
		.len_type_i(frame_len_type_i),
		.data_length_i(frame_data_length_i),
		.dest_addr_i(frame_dest_addr_i),
		.length_drop_o(length_drop),
		.fc_drop_o(fc_drop)
	);

	// valid registered one cycle after the descriptor; high for that one cycle only
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			decision_valid_o <= 1'b0;
		end else begin
			decision_valid_o <= frame_valid_i;
		end
	end

	// a dropped frame is never flooded, so the mask is cleared with it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			decision_drop_o <= 1'b0;
			decision_length_drop_o <= 1'b0;
			decision_fc_drop_o <= 1'b0;
			decision_flood_o <= 1'b0;
			decision_port_mask_o <= '0;
			decision_category_o <= switch_forward_mac_control_pkg::CAT_NONE;
		end else if (frame_valid_i) begin
			decision_drop_o <= length_drop || fc_drop;
			decision_length_drop_o <= length_drop;
			decision_fc_drop_o <= fc_drop;
			decision_flood_o <= flood && !(length_drop || fc_drop);
			decision_port_mask_o <= (length_drop || fc_drop) ? '0 : port_mask;
			decision_category_o <= category;
		end
	end

	// ------------------------------------------------------------------------
	// per-port back-off controls
	// ------------------------------------------------------------------------
	// full-duplex ports never see back-off modes, whatever software wrote
	genvar p;
	generate
		for (p = 0; p < `PORT_COUNT; p++) begin : g_port
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					alt_backoff_o[p] <= 1'b0;
					aggr_backoff_o[p] <= 1'b0;
				end else begin
					alt_backoff_o[p] <= mac_control_zero_reg[`MC0_ALT_BACKOFF_BIT]
						&& port_half_duplex_i[p];
					aggr_backoff_o[p] <= mac_control_zero_reg[`MC0_AGGR_BACKOFF_BIT]
						&& port_half_duplex_i[p];
				end
			end
		end
	endgenerate

	// global settings mirrored to the mac datapath
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			length_check_en_o <= 1'b1;
			fc_drop_either_o <= 1'b1;
		end else begin
			length_check_en_o <= mac_control_zero_reg[`MC0_LENGTH_CHECK_BIT];
			fc_drop_either_o <= mac_control_zero_reg[`MC0_FC_DROP_EITHER_BIT];
		end
	end

endmodule : switch_forward_mac_control

/* sim/switch_forward_mac_control_asserts.sv */
`timescale 1ns/100ps
`include "switch_forward_mac_control_defines.svh"

module switch_forward_mac_control_asserts (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// register port
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	// frame decision
	input wire logic frame_valid_i,
	input wire logic decision_valid_o,
	input wire logic decision_drop_o,
	input wire logic decision_length_drop_o,
	input wire logic decision_fc_drop_o,
	input wire logic decision_flood_o,
	input wire logic [2:0] decision_port_mask_o,
	// back-off
	input wire logic [2:0] port_half_duplex_i,
	input wire logic [2:0] alt_backoff_o,
	input wire logic [2:0] aggr_backoff_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	// ------------------------------------------------------------------------
	// register port
	// ------------------------------------------------------------------------
	// write of the mac control byte, an idle write cycle, then a read of it
	sequence s_mc0_write;
		reg_write_i && reg_addr_i == `SWITCH_MAC_CONTROL_ZERO_ADDR;
	endsequence
	sequence s_mc0_read;
		reg_read_i && !reg_write_i && reg_addr_i == `SWITCH_MAC_CONTROL_ZERO_ADDR;
	endsequence
	a_read_answer: assert property (reg_read_i |=> reg_rvalid_o) else $error("no read answer");
	a_rvalid_cause: assert property (!reg_read_i |=> !reg_rvalid_o) else $error("stray rvalid");
	a_mc0_readback: assert property (s_mc0_write ##1 !reg_write_i ##1 s_mc0_read |=>
		reg_rdata_o == $past(reg_wdata_i, 3)) else $error("mac control readback");
	// reserved bits of the vlan register never read back as one
	a_reserved_zero: assert property (reg_read_i && reg_addr_i inside {16'h0329, 16'h032a,
		16'h032b} |=> reg_rdata_o[7:3] == 5'h00) else $error("reserved bits set");

	// ------------------------------------------------------------------------
	// frame decision and back-off
	// ------------------------------------------------------------------------
	a_decision_pulse: assert property (frame_valid_i |=> decision_valid_o) else $error("no decision");
	a_drop_causes: assert property (decision_valid_o |-> decision_drop_o ==
		(decision_length_drop_o || decision_fc_drop_o)) else $error("drop cause mismatch");
	a_drop_no_flood: assert property (decision_valid_o && decision_drop_o |->
		!decision_flood_o && decision_port_mask_o == 3'h0) else $error("dropped frame flooded");
	a_alt_gate: assert property ((alt_backoff_o & ~$past(port_half_duplex_i)) == 3'h0)
		else $error("alt back-off on full duplex");
	a_aggr_gate: assert property ((aggr_backoff_o & ~$past(port_half_duplex_i)) == 3'h0)
		else $error("aggr back-off on full duplex");
endmodule : switch_forward_mac_control_asserts

bind switch_forward_mac_control switch_forward_mac_control_asserts u_asserts (.clock_i, .reset_i,
	.reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .reg_rvalid_o,
	.frame_valid_i, .decision_valid_o, .decision_drop_o, .decision_length_drop_o,
	.decision_fc_drop_o, .decision_flood_o, .decision_port_mask_o, .port_half_duplex_i,
	.alt_backoff_o, .aggr_backoff_o);

/* sim/testbench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end

module testbench;
	logic clock_i = 1'b0, reset_i = 1'b1, reg_write_i = 1'b0, reg_read_i = 1'b0, frame_valid_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000, lt = 16'h0000, dl = 16'h0000;
	logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
	logic [47:0] da = 48'h0;
	logic vu = 1'b0, uu = 1'b0, mu = 1'b0, ue = 1'b0, me = 1'b0;
	logic [2:0] um = 3'h0, mm = 3'h0, hd = 3'h0, pm, alt, aggr;
	logic reg_rvalid_o, dv, drop, ldrop, fdrop, flood, lce, fce;
	switch_forward_mac_control_pkg::unknown_category_t cat;
	int bad_count = 0, n_tests = 0, cycles = 0;

	switch_forward_mac_control DUT (.clock_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
		.reg_read_i, .reg_rdata_o, .reg_rvalid_o, .frame_valid_i, .frame_vid_unknown_i(vu),
		.frame_uc_unknown_i(uu), .frame_mc_unknown_i(mu), .frame_len_type_i(lt),
		.frame_data_length_i(dl), .frame_dest_addr_i(da), .uc_forward_en_i(ue),
		.uc_port_mask_i(um), .mc_forward_en_i(me), .mc_port_mask_i(mm), .decision_valid_o(dv),
		.decision_drop_o(drop), .decision_length_drop_o(ldrop), .decision_fc_drop_o(fdrop),
		.decision_flood_o(flood), .decision_port_mask_o(pm), .decision_category_o(cat),
		.port_half_duplex_i(hd), .alt_backoff_o(alt), .aggr_backoff_o(aggr),
		.length_check_en_o(lce), .fc_drop_either_o(fce));

	// ------------------------------------------------------------------------
	// clock, timeout and verdict
	// ------------------------------------------------------------------------
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	// generous ceiling: the whole sequence needs well under 500 cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			close_out();
		end
	end
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------------------
	// access tasks, inputs change on the falling edge
	// ------------------------------------------------------------------------
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clock_i) {reg_addr_i, reg_wdata_i, reg_write_i} = {a, d, 1'b1};
		@(negedge clock_i) reg_write_i = 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clock_i) {reg_addr_i, reg_read_i} = {a, 1'b1};
		@(negedge clock_i) reg_read_i = 1'b0;
		`CHK("rvalid", 1'b1, reg_rvalid_o)
		`CHK("rdata", e, reg_rdata_o)
	endtask : rd
	// one descriptor; decision fields hold afterwards for checking
	task frm(input logic [2:0] k, input logic [15:0] t, input logic [15:0] n, input logic [47:0] a);
		@(negedge clock_i) {frame_valid_i, vu, uu, mu, lt, dl, da} = {1'b1, k, t, n, a};
		@(negedge clock_i) frame_valid_i = 1'b0;
		`CHK("dvalid", 1'b1, dv)
	endtask : frm

	// ------------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clock_i);
		@(negedge clock_i) reset_i = 1'b0;
		rd(16'h0328, 8'h00);
		rd(16'h032b, 8'h00);
		rd(16'h0330, 8'h0e);
		`CHK("lce", 1'b1, lce)
		`CHK("fce", 1'b1, fce)
		rd(16'h0340, 8'h00);
		$display("test reset done");
		wr(16'h0328, 8'h80);
		for (int m = 0; m < 8; m++) begin
			wr(16'h032b, 8'hf8 | m[7:0]);
			rd(16'h032b, m[7:0]);
			frm(3'h4, 16'h0800, 16'h0000, 48'h0);
			`CHK("flood", 1'b1, flood)
			`CHK("mask", m[2:0], pm)
		end
		wr(16'h0328, 8'h00);
		frm(3'h4, 16'h0800, 16'h0000, 48'h0);
		`CHK("off", 4'h0, {flood, pm})
		$display("test vlan done");
		{ue, um, me, mm} = 8'hac;
		wr(16'h0328, 8'h80);
		wr(16'h032b, 8'h01);
		frm(3'h7, 16'h0800, 16'h0000, 48'h0);
		`CHK("cat", 5'h09, {cat, pm})
		frm(3'h3, 16'h0800, 16'h0000, 48'h0);
		`CHK("cat", 5'h12, {cat, pm})
		frm(3'h1, 16'h0800, 16'h0000, 48'h0);
		`CHK("cat", 5'h1c, {cat, pm})
		$display("test precedence done");
		frm(3'h0, 16'h05db, 16'h0010, 48'h0);
		`CHK("ldrop", 2'h3, {ldrop, drop})
		frm(3'h0, 16'h05dc, 16'h0010, 48'h0);
		`CHK("ldrop", 2'h0, {ldrop, drop})
		frm(3'h0, 16'h0040, 16'h0040, 48'h0);
		`CHK("ldrop", 2'h0, {ldrop, drop})
		`CHK("cat", 2'h0, cat)
		for (int md = 0; md < 2; md++) begin
			wr(16'h0330, md ? 8'h06 : 8'h04);
			frm(3'h0, 16'h0040, 16'h0010, 48'h0);
			`CHK("ldrop", 1'b0, ldrop)
			`CHK("mirror", {1'b0, md[0]}, {lce, fce})
			for (int c = 0; c < 4; c++) begin
				frm(3'h0, c[0] ? 16'h8808 : 16'h0800, 16'h0000,
					c[1] ? 48'h0180_c200_0001 : 48'h0180_c200_0002);
				`CHK("fdrop", md ? (c != 0) : (c == 3), fdrop)
			end
		end
		$display("test drop done");
		hd = 3'h5;
		wr(16'h0330, 8'h81);
		rd(16'h0330, 8'h81);
		`CHK("alt", 3'h5, alt)
		`CHK("aggr", 3'h5, aggr)
		hd = 3'h2;
		repeat (2) @(negedge clock_i);
		`CHK("alt", 6'h12, {alt, aggr})
		wr(16'h0330, 8'h00);
		repeat (2) @(negedge clock_i);
		`CHK("off", 6'h00, {alt, aggr})
		$display("test backoff done");
		close_out();
	end
endmodule : testbench
